/* design/seac_pkg.sv */
// constants and types shared by the serial eeprom access controller
package seac_pkg;

  // ===========================================================================
  // register indices and byte addresses (byte address = 4 * index)
  localparam logic [9:0] IDX_TEST      = 10'h052;
  localparam logic [9:0] IDX_CTRL      = 10'h054;
  localparam logic [9:0] IDX_ADDR      = 10'h055;
  localparam logic [9:0] IDX_DATA      = 10'h056;
  localparam logic [9:0] IDX_IRQ_STAT  = 10'h058;
  localparam logic [9:0] IDX_IRQ_MASK  = 10'h059;
  localparam logic [11:0] ADDR_TEST     = {IDX_TEST, 2'b00};
  localparam logic [11:0] ADDR_CTRL     = {IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_ADDR     = {IDX_ADDR, 2'b00};
  localparam logic [11:0] ADDR_DATA     = {IDX_DATA, 2'b00};
  localparam logic [11:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

  // ===========================================================================
  // field positions
  localparam int TEST_INHIBIT_BIT = 0;
  localparam int TEST_FAST_BIT    = 1;
  localparam int TEST_STATUS_BIT  = 2;
  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_DIR_BIT     = 1;
  localparam int CTRL_ERR_BIT     = 2;
  localparam int CTRL_OK_BIT      = 3;
  localparam int CTRL_RATE_LSB    = 6;
  localparam int ADDR_WORD_LSB    = 1;
  localparam int IRQ_DONE_BIT     = 0;
  localparam int IRQ_ERR_BIT      = 1;
  localparam int IRQ_AL_BIT       = 2;

  // ===========================================================================
  // reset values
  localparam logic [1:0]  RATE_RESET  = 2'h0;
  localparam logic [2:0]  IRQ_RESET   = 3'h0;
  localparam logic [15:0] DATA_RESET  = 16'h0000;

  // ===========================================================================
  // clock divisors of the primary clock, fast autoload shift
  localparam logic [10:0] DIV_CODE0  = 11'h400;
  localparam logic [10:0] DIV_CODE1  = 11'h200;
  localparam logic [10:0] DIV_CODE2  = 11'h100;
  localparam logic [10:0] DIV_CODE3  = 11'h020;
  localparam int          QTR_SHIFT  = 2;
  localparam int          FAST_SHIFT = 5;

  // ===========================================================================
  // two-wire device selects (generic memory class, chip address zero)
  localparam logic [7:0] EE_SEL_WRITE = 8'ha0;
  localparam logic [7:0] EE_SEL_READ  = 8'ha1;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP} seac_state_t;

endpackage : seac_pkg

/* design/seac_eeprom_ctrl.sv */
// serial eeprom access controller: apb registers, autoload and two-wire engine
//
// How it works
// - test register inhibit bit set to one skips the post-reset autoload
// - fast autoload bit makes autoload run thirty-two times faster, eight times at rate code 11
// - test register bit 2 shows autoload in progress, read only
// - writing one to control start bit launches one eeprom read or write
// - direction bit one sends a write, zero sends a read
// - error bit set when the eeprom fails to acknowledge in a cycle
// - autoload success bit set only after a completed autoload, else zero
// - control bits 5 and 4 always read as zero
// - rate code 00 divides the clock by 1024, code 01 by 512
// - eeprom clock derives from the primary clock, 10 by 256, 11 by 32
// - rate field resets to 00
// - address register bits 7 to 1 give the eeprom word address
// - a write cycle sends the sixteen-bit data register
// - a completed software read places the received word in the data register
`timescale 1ns/100ps
module seac_eeprom_ctrl
  import seac_pkg::*;
#(
  parameter int AW       = 12,
  parameter int AL_WORDS = 4,
  parameter int AL_DELAY = 16
)
(
  input  wire logic          clock_i,
  input  wire logic          resetn_i,
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [AW-1:0] paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  output logic               ee_scl_o,
  output logic               ee_sda_o,
  output logic               ee_sda_oe_o,
  input  wire logic          ee_sda_i,
  output logic               irq_o,
  output logic      [15:0]   al_word_o,
  output logic      [6:0]    al_addr_o,
  output logic               al_valid_o
);

  generate
    if (AW < 12 || AL_WORDS < 1 || AL_WORDS > 128 || AL_DELAY < 1 || AL_DELAY > 255)
    begin : g_bad_params
      $error("seac_eeprom_ctrl: unsupported parameter values");
    end
  endgenerate

  // ===========================================================================
  // state
  logic        inhibit;
  logic        fast;
  logic        start_bit;
  logic        dir_bit;
  logic        err_bit;
  logic        al_ok;
  logic [1:0]  rate;
  logic [6:0]  word_addr;
  logic [15:0] data_reg;
  logic [2:0]  irq_stat;
  logic [2:0]  irq_mask;
  seac_state_t state;
  logic [1:0]  qtr;
  logic [3:0]  bitn;
  logic [2:0]  bidx;
  logic [7:0]  shreg;
  logic [15:0] rx_word;
  logic        cur_write;
  logic        cur_al;
  logic [6:0]  cur_addr;
  logic        op_err;
  logic [8:0]  tick_cnt;
  logic        sda_s1;
  logic        sda_s2;
  logic        al_active;
  logic [6:0]  al_cnt;
  logic [7:0]  al_wait;

  // ===========================================================================
  // apb decode
  wire       wr_en      = psel_i & penable_i & pwrite_i;
  wire       hit_test   = paddr_i == AW'(ADDR_TEST);
  wire       hit_ctrl   = paddr_i == AW'(ADDR_CTRL);
  wire       hit_addr   = paddr_i == AW'(ADDR_ADDR);
  wire       hit_data   = paddr_i == AW'(ADDR_DATA);
  wire       hit_istat  = paddr_i == AW'(ADDR_IRQ_STAT);
  wire       hit_imask  = paddr_i == AW'(ADDR_IRQ_MASK);
  wire       hit_any    = hit_test | hit_ctrl | hit_addr | hit_data | hit_istat | hit_imask;
  wire [7:0] test_rd    = {5'h00, al_active, fast, inhibit};
  wire [7:0] ctrl_rd    = {rate, 2'b00, al_ok, err_bit, dir_bit, start_bit};
  wire [31:0] rd_mux    = hit_test  ? {24'h000000, test_rd} :
                          hit_ctrl  ? {24'h000000, ctrl_rd} :
                          hit_addr  ? {24'h000000, word_addr, 1'b0} :
                          hit_data  ? {16'h0000, data_reg} :
                          hit_istat ? {29'h00000000, irq_stat} :
                          hit_imask ? {29'h00000000, irq_mask} : 32'h00000000;

  assign pready_o  = psel_i & penable_i;
  assign pslverr_o = psel_i & penable_i & ~hit_any;

  // ===========================================================================
  // serial clock timing: a bit slot is four quarters
  wire [10:0] div_sel   = (rate == 2'h0) ? DIV_CODE0 :
                          (rate == 2'h1) ? DIV_CODE1 :
                          (rate == 2'h2) ? DIV_CODE2 : DIV_CODE3;
  wire [8:0]  qtr_norm  = 9'(div_sel >> QTR_SHIFT);
  wire [8:0]  qtr_fast0 = 9'(div_sel >> (QTR_SHIFT + FAST_SHIFT));
  wire [8:0]  qtr_fast  = (qtr_fast0 == 9'h000) ? 9'h001 : qtr_fast0;
  wire [8:0]  qtr_len   = (cur_al && fast) ? qtr_fast : qtr_norm;
  wire        busy      = state != ST_IDLE;
  wire        tick      = busy && (tick_cnt == qtr_len - 9'h001);
  wire        slot_end  = tick && (qtr == 2'h3);
  wire        sample    = tick && (qtr == 2'h2);

  // ===========================================================================
  // transaction plan
  wire       rx_byte   = !cur_write && (bidx >= 3'h3);
  wire [2:0] last_idx  = cur_write ? 3'h3 : 3'h4;
  wire [2:0] load_idx  = (state == ST_START) ? bidx : 3'(bidx + 3'h1);
  wire [7:0] tx_sel    = (load_idx == 3'h0) ? EE_SEL_WRITE :
                         (load_idx == 3'h1) ? {cur_addr, 1'b0} :
                         (load_idx == 3'h2 && !cur_write) ? EE_SEL_READ :
                         (load_idx == 3'h2) ? data_reg[15:8] : data_reg[7:0];
  wire       bit_out   = (bitn < 4'h8) ? (rx_byte | shreg[7]) :
                         (rx_byte ? (bidx == last_idx) : 1'b1);
  wire       sda_hi    = (state == ST_START) ? (qtr < 2'h2) :
                         (state == ST_STOP)  ? (qtr >= 2'h2) :
                         (state == ST_BITS)  ? bit_out : 1'b1;
  wire       scl_hi    = busy && (qtr == 2'h1 || qtr == 2'h2);
  wire       nack_now  = sample && state == ST_BITS && bitn == 4'h8 && !rx_byte && sda_s2;
  wire       done      = slot_end && state == ST_STOP;
  wire       sw_done   = done && !cur_al;
  wire       al_done   = done && cur_al;
  wire       al_last   = al_cnt == 7'(AL_WORDS - 1);
  wire       al_go     = !busy && al_active && al_wait == 8'h00 && !inhibit;
  wire       al_skip   = !busy && al_active && inhibit;
  wire       sw_go     = !busy && start_bit && !al_active;
  wire       launch    = al_go || sw_go;

  // ===========================================================================
  // interrupts
  wire [2:0] irq_evt   = {al_done | al_skip, nack_now, sw_done};
  wire [2:0] irq_clr   = (wr_en && hit_istat) ? pwdata_i[2:0] : 3'h0;
  wire [2:0] next_irq  = (irq_stat & ~irq_clr) | irq_evt;

  assign irq_o = |(irq_stat & irq_mask);

  // ===========================================================================
  // apb read data, captured in the setup cycle
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prdata_o <= 32'h00000000;
    else if (psel_i && !penable_i)
      prdata_o <= rd_mux;
  end

  // ===========================================================================
  // software registers
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      inhibit   <= 1'b0;
      fast      <= 1'b0;
      dir_bit   <= 1'b0;
      rate      <= RATE_RESET;
      word_addr <= 7'h00;
      irq_mask  <= IRQ_RESET;
      irq_stat  <= IRQ_RESET;
    end
    else
    begin
      irq_stat <= next_irq;
      if (wr_en && hit_test)
        {fast, inhibit} <= pwdata_i[TEST_INHIBIT_BIT +: 2];
      if (wr_en && hit_ctrl)
      begin
        dir_bit <= pwdata_i[CTRL_DIR_BIT];
        rate    <= pwdata_i[CTRL_RATE_LSB +: 2];
      end
      if (wr_en && hit_addr)
        word_addr <= pwdata_i[ADDR_WORD_LSB +: 7];
      if (wr_en && hit_imask)
        irq_mask <= pwdata_i[2:0];
    end
  end

  // start request: a new write of one wins over the completion clear
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      start_bit <= 1'b0;
    else if (wr_en && hit_ctrl && pwdata_i[CTRL_START_BIT])
      start_bit <= 1'b1;
    else if (sw_done)
      start_bit <= 1'b0;
  end

  // completed read beats a software write in the same cycle
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      data_reg <= DATA_RESET;
    else if (sw_done && !cur_write && !op_err)
      data_reg <= rx_word;
    else if (wr_en && hit_data)
      data_reg <= pwdata_i[15:0];
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      err_bit <= 1'b0;
    else if (nack_now)
      err_bit <= 1'b1;
    else if (launch)
      err_bit <= 1'b0;
  end

  // ===========================================================================
  // autoload sequencing
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      al_active  <= 1'b1;
      al_ok      <= 1'b0;
      al_cnt     <= 7'h00;
      al_wait    <= 8'(AL_DELAY);
      al_valid_o <= 1'b0;
      al_word_o  <= 16'h0000;
      al_addr_o  <= 7'h00;
    end
    else
    begin
      al_valid_o <= 1'b0;
      if (al_wait != 8'h00)
        al_wait <= al_wait - 8'h01;
      if (al_skip || (al_done && op_err))
        al_active <= 1'b0;
      if (al_done && !op_err)
      begin
        al_valid_o <= 1'b1;
        al_word_o  <= rx_word;
        al_addr_o  <= cur_addr;
        al_cnt     <= 7'(al_cnt + 7'h01);
        if (al_last)
        begin
          al_active <= 1'b0;
          al_ok     <= 1'b1;
        end
      end
    end
  end

  // ===========================================================================
  // two-wire engine
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      {sda_s2, sda_s1} <= 2'b11;
    else
      {sda_s2, sda_s1} <= {sda_s1, ee_sda_i};
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      tick_cnt <= 9'h000;
    else if (!busy || tick)
      tick_cnt <= 9'h000;
    else
      tick_cnt <= tick_cnt + 9'h001;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      {ee_scl_o, ee_sda_o, ee_sda_oe_o} <= 3'b100;
    else
      {ee_scl_o, ee_sda_o, ee_sda_oe_o} <= {!busy || scl_hi, 1'b0, !sda_hi};
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state     <= ST_IDLE;
      {qtr, bitn, bidx} <= 9'h000;
      shreg     <= 8'h00;
      rx_word   <= 16'h0000;
      {cur_write, cur_al, op_err} <= 3'b000;
      cur_addr  <= 7'h00;
    end
    else if (launch)
    begin
      state     <= ST_START;
      qtr       <= 2'h0;
      bidx      <= 3'h0;
      op_err    <= 1'b0;
      cur_al    <= al_go;
      cur_write <= al_go ? 1'b0 : dir_bit;
      cur_addr  <= al_go ? al_cnt : word_addr;
    end
    else if (tick)
    begin
      qtr <= 2'(qtr + 2'h1);
      if (nack_now)
        op_err <= 1'b1;
      if (sample && state == ST_BITS && bitn < 4'h8 && rx_byte)
        shreg <= {shreg[6:0], sda_s2};
      if (slot_end)
      begin
        unique case (state)
          ST_START:
          begin
            state <= ST_BITS;
            bitn  <= 4'h0;
            shreg <= tx_sel;
          end
          ST_BITS:
          begin
            if (bitn < 4'h8)
            begin
              bitn <= bitn + 4'h1;
              if (!rx_byte)
                shreg <= {shreg[6:0], 1'b0};
            end
            else
            begin
              if (rx_byte)
                rx_word <= {rx_word[7:0], shreg};
              if (op_err || bidx == last_idx)
                state <= ST_STOP;
              else if (!cur_write && bidx == 3'h1)
              begin
                state <= ST_START;
                bidx  <= 3'h2;
              end
              else
              begin
                bidx  <= 3'(bidx + 3'h1);
                bitn  <= 4'h0;
                shreg <= tx_sel;
              end
            end
          end
          ST_STOP, ST_IDLE:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // ===========================================================================
  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  inhibit_skip_a: assert property ((!busy && al_active && inhibit) |=> !al_active && !busy)
    else $error("autoload not skipped while inhibited");
  al_status_a: assert property ((psel_i && !penable_i && hit_test) |=>
    prdata_o[TEST_STATUS_BIT] == $past(al_active))
    else $error("autoload status bit wrong");
  start_go_a: assert property ((sw_go) |=> state == ST_START && !cur_al)
    else $error("start bit did not launch a cycle");
  dir_cmd_a: assert property ((sw_go && dir_bit) |=> cur_write)
    else $error("direction not taken");
  nack_err_a: assert property (nack_now |=> err_bit && op_err)
    else $error("missing acknowledge not flagged");
  al_ok_a: assert property ($rose(al_ok) |-> $past(al_done) && !$past(op_err))
    else $error("autoload success without completion");
  ctrl_rsv_a: assert property ((psel_i && !penable_i && hit_ctrl) |=> prdata_o[5:4] == 2'b00)
    else $error("reserved control bits not zero");
  qtr_len_a: assert property ((!(cur_al && fast) && rate == 2'h0 && busy) |-> qtr_len == 9'h100)
    else $error("divide by 1024 quarter wrong");
  rd_load_a: assert property ((sw_done && !cur_write && !op_err) |=> data_reg == $past(rx_word))
    else $error("read word not loaded");
  start_clr_a: assert property ((sw_done && !(wr_en && hit_ctrl)) |=> !start_bit)
    else $error("start bit not cleared at completion");

  read_cycle_c: cover property (sw_done && !cur_write && !op_err);
  write_cycle_c: cover property (sw_done && cur_write);
  autoload_ok_c: cover property ($rose(al_ok));
  nack_seen_c: cover property (nack_now);

endmodule : seac_eeprom_ctrl

/* testbench/seac_eeprom_model.sv */
// behavioural two-wire configuration eeprom answering the access controller
`timescale 1ns/100ps
module seac_eeprom_model
(
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic nack_i,
  output logic      sda_oe_o
);
  logic [15:0] mem [128];
  logic [7:0]  shreg;
  logic [6:0]  waddr;
  logic [15:0] word;
  int          cnt;
  int          nbyte;
  logic        fresh;
  logic        tx;
  logic        go_tx;
  logic        mack;

  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = {8'(i) ^ 8'h5a, 8'(i)};
    sda_oe_o = 1'b0;
    tx = 1'b0;
    go_tx = 1'b0;
    fresh = 1'b0;
    cnt = 0;
  end

  // ==========================================================================
  // start or repeated start: data falls while clock is high
  always @(negedge sda_i)
    if (scl_i === 1'b1)
    begin
      fresh = 1'b1;
      cnt = 0;
      nbyte = 0;
      tx = 1'b0;
    end

  always @(posedge scl_i)
    if (!tx && cnt < 8)
      shreg = {shreg[6:0], sda_i};
    else if (tx && cnt == 8)
      mack = ~sda_i;

  // ==========================================================================
  // bit counting, acknowledge and word return on the falling clock
  always @(negedge scl_i)
    if (fresh)
      fresh = 1'b0;
    else
    begin
      cnt = cnt + 1;
      if (cnt == 8 && tx)
        sda_oe_o = 1'b0;
      else if (cnt == 8)
      begin
        sda_oe_o = ~nack_i;
        if (!nack_i)
        begin
          case (nbyte)
            0: go_tx = (shreg == 8'ha1);
            1: waddr = shreg[7:1];
            2: word[15:8] = shreg;
            3: mem[waddr] = {word[15:8], shreg};
            default: ;
          endcase
          nbyte++;
        end
      end
      else if (cnt == 9)
      begin
        cnt = 0;
        sda_oe_o = 1'b0;
        if (go_tx)
          word = mem[waddr];
        else if (tx && mack)
          word = {word[7:0], 8'h00};
        tx = go_tx || (tx && mack);
        go_tx = 1'b0;
        mack = 1'b0;
        if (tx)
          sda_oe_o = ~word[15];
      end
      else if (tx)
        sda_oe_o = ~word[15-cnt];
    end
endmodule : seac_eeprom_model

/* testbench/serial_eeprom_access_control_test.sv */
// self-checking bench of the serial eeprom access controller
`timescale 1ns/100ps
module serial_eeprom_access_control_test
  import seac_pkg::*;
;
  logic        clock_i, resetn_i, psel, penable, pwrite, nack, err;
  logic        pready, pslverr, scl, sda_o, sda_oe, irq, al_valid, model_oe, sda_w;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] al_word;
  logic [6:0]  al_addr;
  int          n_mismatch, samples_checked, cyc, al_cnt, t0;
  int          divs [4] = '{1024, 512, 256, 32};

  // open-drain data line with pull-up
  assign sda_w = !((sda_oe && !sda_o) || model_oe);

  seac_eeprom_ctrl #(.AL_WORDS(1), .AL_DELAY(16)) u_seac_eeprom_ctrl (
    .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ee_scl_o(scl), .ee_sda_o(sda_o), .ee_sda_oe_o(sda_oe), .ee_sda_i(sda_w), .irq_o(irq),
    .al_word_o(al_word), .al_addr_o(al_addr), .al_valid_o(al_valid));

  seac_eeprom_model u_seac_eeprom_model (.scl_i(scl), .sda_i(sda_w), .nack_i(nack), .sda_oe_o(model_oe));

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // ==========================================================================
  // cycle count, timeout and autoload word monitor
  always @(posedge clock_i)
  begin
    cyc = cyc + 1;
    if (al_valid === 1'b1)
    begin
      al_cnt++;
      chk({al_addr, al_word}, {7'h00, 16'h5a00});
    end
    if (cyc == 60000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1)
      @(posedge clock_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // poll a register until the given bit reads zero
  task automatic wait_clear(input logic [11:0] a, input int b);
    apb(1'b0, a, 32'h0);
    while (rd[b] !== 1'b0)
      apb(1'b0, a, 32'h0);
  endtask : wait_clear

  task automatic irq_is(input logic exp);
    @(negedge clock_i);
    chk(irq, exp);
  endtask : irq_is

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    {resetn_i, psel, penable, pwrite, nack} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    {n_mismatch, samples_checked, cyc, al_cnt} = '0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    // fast autoload after reset
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_TEST, 32'h4);
    t0 = cyc;
    apb(1'b1, ADDR_TEST, 32'h2);
    wait_clear(ADDR_TEST, TEST_STATUS_BIT);
    chk(cyc - t0 < 2000, 1'b1);
    chk(al_cnt, 1);
    rdchk(ADDR_CTRL, 32'h8);
    rdchk(ADDR_IRQ_STAT, 32'h4);
    irq_is(1'b0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h7);
    irq_is(1'b1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h4);
    irq_is(1'b0);
    // software write cycle, reserved control bits written high
    apb(1'b1, ADDR_ADDR, 32'h0b);
    rdchk(ADDR_ADDR, 32'h0a);
    apb(1'b1, ADDR_DATA, 32'h1234beef);
    rdchk(ADDR_DATA, 32'hbeef);
    t0 = cyc;
    apb(1'b1, ADDR_CTRL, 32'hf3);
    rdchk(ADDR_CTRL, 32'hcb);
    wait_clear(ADDR_CTRL, CTRL_START_BIT);
    chk((cyc - t0 > 1000) && (cyc - t0 < 1500), 1'b1);
    chk(u_seac_eeprom_model.mem[5], 16'hbeef);
    irq_is(1'b1);
    rdchk(ADDR_IRQ_STAT, 32'h1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1);
    irq_is(1'b0);
    // software read cycles, written word and top word address
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, ADDR_ADDR, (i == 0) ? 32'h0a : 32'hfe);
      apb(1'b1, ADDR_CTRL, 32'hc1);
      wait_clear(ADDR_CTRL, CTRL_START_BIT);
      rdchk(ADDR_DATA, (i == 0) ? 32'hbeef : 32'h257f);
      rdchk(ADDR_CTRL, 32'hc8);
    end
    // every clock rate, the eeprom refusing to acknowledge
    nack <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, ADDR_CTRL, {24'h0, 2'(c), 6'h01});
      repeat (2) @(posedge scl);
      t0 = cyc;
      @(posedge scl);
      chk(cyc - t0, divs[c]);
      wait_clear(ADDR_CTRL, CTRL_START_BIT);
      rdchk(ADDR_CTRL, {24'h0, 2'(c), 6'h0c});
    end
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd[IRQ_ERR_BIT], 1'b1);
    nack <= 1'b0;
    // unmapped place refused
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // second reset with autoload inhibited
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    al_cnt = 0;
    resetn_i <= 1'b1;
    apb(1'b1, ADDR_TEST, 32'h3);
    repeat (800) @(posedge clock_i);
    chk(al_cnt, 0);
    rdchk(ADDR_TEST, 32'h3);
    rdchk(ADDR_CTRL, 32'h0);
    tally_and_finish();
  end
endmodule : serial_eeprom_access_control_test
